// [src/srsr_regs.vh]
// Register offsets, field positions, reset values and bus constants for the supply status block
`ifndef SRSR_REGS_VH
`define SRSR_REGS_VH

`define SRSR_BASE_ADDR        32'h5000_4000
`define SRSR_END_ADDR         32'h5000_4FFF
`define SRSR_OFS_STATUS       12'h008
`define SRSR_OFS_EXT_CTRL     12'h00C

`define SRSR_RESET_STATUS     32'h0000_0000
`define SRSR_RESET_EXT_CTRL   32'h0000_0000

// Regulator status and clear fields
`define SRSR_ST_PAD_OVL_CLR   13
`define SRSR_ST_PAD_OVV_CLR   12
`define SRSR_ST_OT_CLR        11
`define SRSR_ST_CORE_OVL_CLR  9
`define SRSR_ST_CORE_OVV_CLR  8
`define SRSR_ST_PAD_IRQ_EN    6
`define SRSR_ST_PAD_OVL       5
`define SRSR_ST_PAD_OVV       4
`define SRSR_ST_OT            3
`define SRSR_ST_CORE_IRQ_EN   2
`define SRSR_ST_CORE_OVL      1
`define SRSR_ST_CORE_OVV      0

// External supply control fields
`define SRSR_EX_OT_STS_CLR    13
`define SRSR_EX_UV_IRQ_CLR    12
`define SRSR_EX_OT_IRQ_CLR    11
`define SRSR_EX_STABLE        7
`define SRSR_EX_OT_LIVE       6
`define SRSR_EX_OT_STS        5
`define SRSR_EX_UV_IRQ        4
`define SRSR_EX_OT_IRQ        3
`define SRSR_EX_IRQ_EN        2
`define SRSR_EX_CYC_EN        1
`define SRSR_EX_ON            0

// Bus transfer size code for a full word
`define SRSR_SIZE_WORD        2'b10

// Input synchroniser depth
`define SRSR_SYNC_STAGES      2

`endif

// [src/srsr_sync.v]
// Two-stage synchroniser for a vector of asynchronous condition levels
`timescale 1ns/1ps
`default_nettype none

module srsr_sync #(
	parameter WIDTH = 1
) (
	input  wire             clock,
	input  wire             rst_b,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_q;  // First stage, read only by second stage
	reg [WIDTH-1:0] sync_q;  // Second stage, safe for logic

	// Both stages clear on reset so no flag sets from stale levels
	always @(posedge clock)
	begin
		if (!rst_b)
		begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule

`default_nettype wire

// [src/srsr_top.v]
// Supply regulator status and control register bank
//
// Function
// RQ1: Only full-word accesses; narrower raise hardfault
// RQ2: Decode space 50004000 to 50004FFF
// RQ3: Pad and core fault flags sticky
// RQ4: Bit 13 one clears pad overload
// RQ5: Bits 12, 11 clear pad overvoltage, overtemp
// RQ6: Bits 9, 8 clear core overload, overvoltage
// RQ7: Bit 6 gates pad interrupt
// RQ8: Bit 2 gates core interrupt
// RQ9: Reserved bits read zero
// RQ10: External bit 13 zero clears overtemp status
// RQ11: External bit 12 zero clears undervoltage irq
// RQ12: External bit 11 zero clears overtemp irq
// RQ13: Bit 7 reports external supply stable
// RQ14: Bit 6 live overtemp, bit 5 sticky
// RQ15: External bit 2 gates external interrupt
// RQ16: Bit 0 switches external regulator on
// RQ17: Cyclic sense needs bits 1 and 0
// RQ18: Irq status bits use separate reset
// RQ19: Core or pad overcurrent shuts down, interrupts
// RQ20: External fault wakes from stop mode
// RQ21: Interrupt is OR of gated flags
// RQ22: Read-only writes ignored; clears read zero
`timescale 1ns/1ps
`default_nettype none
`include "srsr_regs.vh"

module srsr_top (
	input  wire        clock,
	input  wire        rst_b,
	input  wire        rst_irq_b,
	// Register bus
	input  wire        bus_sel,
	input  wire        bus_write,
	input  wire [31:0] bus_addr,
	input  wire [1:0]  bus_size,
	input  wire [31:0] bus_wdata,
	output reg  [31:0] bus_rdata,
	output reg         bus_ready,
	output reg         bus_hardfault,
	// Analog condition levels and mode
	input  wire        pad_overload_in,
	input  wire        pad_overvoltage_in,
	input  wire        overtemp_in,
	input  wire        core_overload_in,
	input  wire        core_overvoltage_in,
	input  wire        ext_stable_in,
	input  wire        ext_overtemp_in,
	input  wire        ext_undervoltage_in,
	input  wire        stop_mode,
	// Regulator controls, interrupts and wake
	output reg         pad_shutdown,
	output reg         core_shutdown,
	output reg         pad_irq,
	output reg         core_irq,
	output reg         ext_irq,
	output reg         ext_supply_on,
	output reg         ext_cyclic_supply,
	output reg         stop_wake_req,
	output reg         ext_fault_wake
);

	// Synchronised analog comparator levels
	wire [7:0] cond_sync;
	wire       pad_ovl_s;       // Pad overload level
	wire       pad_ovv_s;       // Pad overvoltage level
	wire       ot_s;            // Overtemperature level
	wire       core_ovl_s;      // Core overload level
	wire       core_ovv_s;      // Core overvoltage level
	wire       ext_stable_s;    // External supply stable level
	wire       ext_ot_s;        // External overtemperature level
	wire       ext_uv_s;        // External undervoltage level

	// Status register state
	reg        pad_ovl_q;       // Sticky pad overload
	reg        pad_ovv_q;       // Sticky pad overvoltage
	reg        ot_q;            // Sticky overtemperature
	reg        core_ovl_q;      // Sticky core overload
	reg        core_ovv_q;      // Sticky core overvoltage
	reg        pad_en_q;        // Pad interrupt enable
	reg        core_en_q;       // Core interrupt enable

	// External control register state
	reg        ext_on_q;        // External supply enable
	reg        ext_cyc_q;       // Cyclic sense supply enable
	reg        ext_en_q;        // External interrupt enable
	reg        ext_ot_sts_q;    // Sticky external overtemp status
	reg        ext_uv_is_q;     // Undervoltage interrupt status
	reg        ext_ot_is_q;     // Overtemp interrupt status

	// Edge history for event detection
	reg        ext_ot_prev_q;   // Previous external overtemp level
	reg        ext_uv_prev_q;   // Previous external undervoltage level

	// Decode terms
	wire        in_space;       // Address inside block window
	wire [11:0] offset;         // Offset within window
	wire        word_ok;        // Full word transfer
	wire        acc_ok;         // Legal access
	wire        wr_status;      // Write to status register
	wire        wr_ext;         // Write to external control
	reg  [31:0] rd_mux;         // Read data selection
	wire        ext_fault_any;  // Either external interrupt status set

	// Comparator levels come from the analog side, unrelated to clock;
	// nothing reads them before the second flop
	srsr_sync #(
		.WIDTH (8)
	) u_sync (
		.clock    (clock),
		.rst_b    (rst_b),
		.async_in ({ext_undervoltage_in, ext_overtemp_in, ext_stable_in,
			core_overvoltage_in, core_overload_in, overtemp_in,
			pad_overvoltage_in, pad_overload_in}),
		.sync_out (cond_sync)
	);

	// Bit order follows the concatenation above
	assign pad_ovl_s    = cond_sync[0];
	assign pad_ovv_s    = cond_sync[1];
	assign ot_s         = cond_sync[2];
	assign core_ovl_s   = cond_sync[3];
	assign core_ovv_s   = cond_sync[4];
	assign ext_stable_s = cond_sync[5];
	assign ext_ot_s     = cond_sync[6];
	assign ext_uv_s     = cond_sync[7];

	// Address and size decode
	assign in_space  = (bus_addr >= `SRSR_BASE_ADDR) && (bus_addr <= `SRSR_END_ADDR); // [RQ2]
	assign offset    = bus_addr[11:0];
	assign word_ok   = (bus_size == `SRSR_SIZE_WORD) && (bus_addr[1:0] == 2'b00); // [RQ1]
	assign acc_ok    = bus_sel && in_space && word_ok;
	assign wr_status = acc_ok && bus_write && (offset == `SRSR_OFS_STATUS);
	assign wr_ext    = acc_ok && bus_write && (offset == `SRSR_OFS_EXT_CTRL);

	// Either external fault status counts as a wake cause
	assign ext_fault_any = ext_uv_is_q | ext_ot_is_q;

	// Read view; clear fields and reserved bits read zero
	// Unmapped offsets inside the window read zero yet still answer ready
	always @*
	begin
		rd_mux = 32'h0000_0000; // [RQ9]
		if (offset == `SRSR_OFS_STATUS)
		begin
			rd_mux[`SRSR_ST_PAD_IRQ_EN]  = pad_en_q;
			rd_mux[`SRSR_ST_PAD_OVL]     = pad_ovl_q;
			rd_mux[`SRSR_ST_PAD_OVV]     = pad_ovv_q;
			rd_mux[`SRSR_ST_OT]          = ot_q;
			rd_mux[`SRSR_ST_CORE_IRQ_EN] = core_en_q;
			rd_mux[`SRSR_ST_CORE_OVL]    = core_ovl_q;
			rd_mux[`SRSR_ST_CORE_OVV]    = core_ovv_q; // [RQ22]
		end
		else if (offset == `SRSR_OFS_EXT_CTRL)
		begin
			// Stable and live overtemp show the synchronised levels
			rd_mux[`SRSR_EX_STABLE]  = ext_stable_s; // [RQ13]
			rd_mux[`SRSR_EX_OT_LIVE] = ext_ot_s; // [RQ14]
			rd_mux[`SRSR_EX_OT_STS]  = ext_ot_sts_q;
			rd_mux[`SRSR_EX_UV_IRQ]  = ext_uv_is_q;
			rd_mux[`SRSR_EX_OT_IRQ]  = ext_ot_is_q;
			rd_mux[`SRSR_EX_IRQ_EN]  = ext_en_q;
			rd_mux[`SRSR_EX_CYC_EN]  = ext_cyc_q;
			rd_mux[`SRSR_EX_ON]      = ext_on_q;
		end
		else
		begin
			rd_mux = 32'h0000_0000;
		end
	end

	// Bus answer: one cycle after select, ready or hardfault
	// Registered answer fixes the bus timing at one cycle; requests
	// outside the window get neither, another block owns them
	always @(posedge clock)
	begin
		if (!rst_b)
		begin
			bus_rdata     <= 32'h0000_0000;
			bus_ready     <= 1'b0;
			bus_hardfault <= 1'b0;
		end
		else
		begin
			bus_ready     <= bus_sel && in_space && word_ok;
			bus_hardfault <= bus_sel && in_space && !word_ok; // [RQ1]
			bus_rdata     <= (acc_ok && !bus_write) ? rd_mux : 32'h0000_0000;
		end
	end

	// Supply status flags: hardware set wins over software clear
	// A clear in the same cycle as a live fault loses, so no onset is missed
	always @(posedge clock)
	begin
		if (!rst_b)
		begin
			pad_ovl_q  <= 1'b0;
			pad_ovv_q  <= 1'b0;
			ot_q       <= 1'b0;
			core_ovl_q <= 1'b0;
			core_ovv_q <= 1'b0;
		end
		else
		begin
			pad_ovl_q  <= pad_ovl_s | (pad_ovl_q &
				~(wr_status & bus_wdata[`SRSR_ST_PAD_OVL_CLR])); // [RQ3] [RQ4]
			pad_ovv_q  <= pad_ovv_s | (pad_ovv_q &
				~(wr_status & bus_wdata[`SRSR_ST_PAD_OVV_CLR])); // [RQ5]
			ot_q       <= ot_s | (ot_q &
				~(wr_status & bus_wdata[`SRSR_ST_OT_CLR])); // [RQ5]
			core_ovl_q <= core_ovl_s | (core_ovl_q &
				~(wr_status & bus_wdata[`SRSR_ST_CORE_OVL_CLR])); // [RQ6]
			core_ovv_q <= core_ovv_s | (core_ovv_q &
				~(wr_status & bus_wdata[`SRSR_ST_CORE_OVV_CLR])); // [RQ6]
		end
	end

	// Interrupt enables are plain read-write bits
	always @(posedge clock)
	begin
		if (!rst_b)
		begin
			pad_en_q  <= 1'b0;
			core_en_q <= 1'b0;
		end
		else if (wr_status)
		begin
			pad_en_q  <= bus_wdata[`SRSR_ST_PAD_IRQ_EN]; // [RQ7]
			core_en_q <= bus_wdata[`SRSR_ST_CORE_IRQ_EN]; // [RQ8]
		end
	end

	// External control bits; main reset class
	always @(posedge clock)
	begin
		if (!rst_b)
		begin
			ext_on_q      <= 1'b0;
			ext_cyc_q     <= 1'b0;
			ext_en_q      <= 1'b0;
			ext_ot_sts_q  <= 1'b0;
			ext_ot_prev_q <= 1'b0;
			ext_uv_prev_q <= 1'b0;
		end
		else
		begin
			// Edge history idles low like its pins, so no false edge after reset
			ext_ot_prev_q <= ext_ot_s;
			ext_uv_prev_q <= ext_uv_s;
			// Control bits follow every full-word write to the external control offset
			if (wr_ext)
			begin
				ext_on_q  <= bus_wdata[`SRSR_EX_ON]; // [RQ16]
				ext_cyc_q <= bus_wdata[`SRSR_EX_CYC_EN];
				ext_en_q  <= bus_wdata[`SRSR_EX_IRQ_EN];
			end
			// Inverted clear: zero clears, set still wins
			ext_ot_sts_q <= ext_ot_s | (ext_ot_sts_q &
				~(wr_ext & ~bus_wdata[`SRSR_EX_OT_STS_CLR])); // [RQ10] [RQ14]
		end
	end

	// Interrupt status bits on their own reset class
	// Only these two bits follow the second reset class
	// Rising edges only, so a standing fault sets once per onset
	always @(posedge clock)
	begin
		if (!rst_irq_b)
		begin
			ext_uv_is_q <= 1'b0; // [RQ18]
			ext_ot_is_q <= 1'b0;
		end
		else
		begin
			// Undervoltage only counts while supply is switched on
			ext_uv_is_q <= (ext_uv_s & ~ext_uv_prev_q & ext_on_q) | (ext_uv_is_q &
				~(wr_ext & ~bus_wdata[`SRSR_EX_UV_IRQ_CLR])); // [RQ11]
			ext_ot_is_q <= (ext_ot_s & ~ext_ot_prev_q) | (ext_ot_is_q &
				~(wr_ext & ~bus_wdata[`SRSR_EX_OT_IRQ_CLR])); // [RQ12]
		end
	end

	// Shutdowns: overcurrent holds its regulator off while the flag stands
	always @(posedge clock)
	begin
		if (!rst_b)
		begin
			pad_shutdown  <= 1'b0;
			core_shutdown <= 1'b0;
		end
		else
		begin
			pad_shutdown  <= pad_ovl_q; // [RQ19]
			core_shutdown <= core_ovl_q; // [RQ19]
		end
	end

	// Interrupt requests: OR of each regulator's flags behind its enable
	always @(posedge clock)
	begin
		if (!rst_b)
		begin
			pad_irq  <= 1'b0;
			core_irq <= 1'b0;
			ext_irq  <= 1'b0;
		end
		else
		begin
			pad_irq  <= pad_en_q & (pad_ovl_q | pad_ovv_q | ot_q); // [RQ7] [RQ21]
			core_irq <= core_en_q & (core_ovl_q | core_ovv_q); // [RQ8] [RQ21]
			ext_irq  <= ext_en_q & (ext_uv_is_q | ext_ot_is_q); // [RQ15] [RQ21]
		end
	end

	// Supply switch: cyclic sense only rides on a switched-on supply
	always @(posedge clock)
	begin
		if (!rst_b)
		begin
			ext_supply_on     <= 1'b0;
			ext_cyclic_supply <= 1'b0;
		end
		else
		begin
			ext_supply_on     <= ext_on_q; // [RQ16]
			ext_cyclic_supply <= ext_on_q & ext_cyc_q; // [RQ17]
		end
	end

	// Stop-mode wake; a faulty external supply would fake or miss wakes
	always @(posedge clock)
	begin
		if (!rst_b)
		begin
			stop_wake_req  <= 1'b0;
			ext_fault_wake <= 1'b0;
		end
		else
		begin
			stop_wake_req <= stop_mode & ext_fault_any; // [RQ20]
			// Wake cause sticks until the main reset
			if (stop_mode & ext_fault_any)
			begin
				ext_fault_wake <= 1'b1; // [RQ20]
			end
		end
	end

endmodule

`default_nettype wire

// [testbench/srsr_props.sv]
// Checker for bus answers, interrupt gating and supply outputs
`timescale 1ns/1ps
`default_nettype none
module srsr_props (
	input wire        clock,
	input wire        rst_b,
	input wire        bus_sel,
	input wire        bus_write,
	input wire [31:0] bus_addr,
	input wire [1:0]  bus_size,
	input wire [31:0] bus_wdata,
	input wire [31:0] bus_rdata,
	input wire        bus_ready,
	input wire        bus_hardfault,
	input wire        stop_mode,
	input wire        pad_irq,
	input wire        core_irq,
	input wire        ext_irq,
	input wire        ext_supply_on,
	input wire        ext_cyclic_supply,
	input wire        stop_wake_req
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	// Request inside the block's window
	wire win = bus_sel && bus_addr[31:12] == 20'h5_0004;
	// Legal aligned word request
	wire ok = win && bus_size == 2'b10 && bus_addr[1:0] == 2'b00;
	sequence wr_st;
		ok && bus_write && bus_addr[11:0] == 12'h008;
	endsequence
	sequence wr_ext;
		ok && bus_write && bus_addr[11:0] == 12'h00C;
	endsequence
	AST_READY: assert property (ok |=> bus_ready && !bus_hardfault)
		else $error("word access not completed");
	AST_FAULT: assert property (win && bus_size != 2'b10 |=> bus_hardfault && !bus_ready)
		else $error("narrow access not faulted");
	AST_ALIGN: assert property (win && bus_addr[1:0] != 2'b00 |=> bus_hardfault)
		else $error("misaligned access not faulted");
	AST_OUTSIDE: assert property (bus_sel && !win |=> !bus_ready && !bus_hardfault)
		else $error("answer outside window");
	AST_RSVD: assert property (bus_ready |-> bus_rdata[31:14] == 18'h0_0000)
		else $error("reserved bits set");
	AST_PAD_GATE: assert property (wr_st ##0 !bus_wdata[6] |=> ##1 !pad_irq)
		else $error("pad irq while disabled");
	AST_CORE_GATE: assert property (wr_st ##0 !bus_wdata[2] |=> ##1 !core_irq)
		else $error("core irq while disabled");
	AST_EXT_GATE: assert property (wr_ext ##0 !bus_wdata[2] |=> ##1 !ext_irq)
		else $error("ext irq while disabled");
	AST_ON: assert property (wr_ext |=> ##1 ext_supply_on == $past(bus_wdata[0], 2))
		else $error("supply on does not follow");
	AST_CYC: assert property (ext_cyclic_supply |-> ext_supply_on)
		else $error("cyclic without supply");
	AST_WAKE: assert property (stop_wake_req |-> $past(stop_mode))
		else $error("wake outside stop");
endmodule
bind srsr_top srsr_props chk_u (.clock(clock), .rst_b(rst_b), .bus_sel(bus_sel),
	.bus_write(bus_write), .bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata),
	.bus_rdata(bus_rdata), .bus_ready(bus_ready), .bus_hardfault(bus_hardfault),
	.stop_mode(stop_mode), .pad_irq(pad_irq), .core_irq(core_irq), .ext_irq(ext_irq),
	.ext_supply_on(ext_supply_on), .ext_cyclic_supply(ext_cyclic_supply),
	.stop_wake_req(stop_wake_req));
`default_nettype wire

// [testbench/srsr_cpu_model.sv]
// Processor-side master issuing single register accesses
`timescale 1ns/1ps
`default_nettype none
module srsr_cpu_model (
	input  wire         clock,
	output logic        bus_sel,
	output logic        bus_write,
	output logic [31:0] bus_addr,
	output logic [1:0]  bus_size,
	output logic [31:0] bus_wdata,
	input  wire  [31:0] bus_rdata,
	input  wire         bus_ready,
	input  wire         bus_hardfault
);
	// Idle bus at time zero
	initial
	begin
		bus_sel = 1'b0;
		bus_write = 1'b0;
		bus_addr = 32'h0000_0000;
		bus_size = 2'b10;
		bus_wdata = 32'h0000_0000;
	end
	// One request cycle, answer sampled one cycle later; on release address and write data invert
	task xfer(input logic w, input logic [31:0] a, input logic [1:0] s,
		input logic [31:0] d, output logic [31:0] q, output logic [1:0] ans);
		@(negedge clock);
		bus_sel = 1'b1;
		bus_write = w;
		bus_addr = a;
		bus_size = s;
		bus_wdata = d;
		@(negedge clock);
		bus_sel = 1'b0;
		bus_addr = ~a;
		bus_wdata = ~d;
		q = bus_rdata;
		ans = {bus_hardfault, bus_ready};
	endtask
endmodule
`default_nettype wire

// [testbench/supply_regulator_status_regs_tb_top.sv]
// Bench driving the supply status register bank through the processor model
`timescale 1ns/1ps
`default_nettype none
module supply_regulator_status_regs_tb_top;
	logic        clock, rst_b, rst_irq_b, stop_mode;
	logic [7:0]  cond;       // Condition inputs, pad overload first
	logic [31:0] q;          // Read data seen
	logic [1:0]  ans;        // Hardfault and ready seen
	wire         bus_sel, bus_write, bus_ready, bus_hardfault;
	wire  [31:0] bus_addr, bus_wdata, bus_rdata;
	wire  [1:0]  bus_size;
	wire  [8:0]  o;          // Shutdown, irq, supply and wake outputs
	int          fail_count = 0;
	int          samples_checked = 0;
	srsr_cpu_model bm_u (.clock(clock), .bus_sel(bus_sel), .bus_write(bus_write),
		.bus_addr(bus_addr), .bus_size(bus_size), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .bus_ready(bus_ready), .bus_hardfault(bus_hardfault));
	srsr_top dut_u (.clock(clock), .rst_b(rst_b), .rst_irq_b(rst_irq_b), .bus_sel(bus_sel),
		.bus_write(bus_write), .bus_addr(bus_addr), .bus_size(bus_size),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ready(bus_ready),
		.bus_hardfault(bus_hardfault), .pad_overload_in(cond[7]),
		.pad_overvoltage_in(cond[6]), .overtemp_in(cond[5]), .core_overload_in(cond[4]),
		.core_overvoltage_in(cond[3]), .ext_stable_in(cond[2]), .ext_overtemp_in(cond[1]),
		.ext_undervoltage_in(cond[0]), .stop_mode(stop_mode), .pad_shutdown(o[8]),
		.core_shutdown(o[7]), .pad_irq(o[6]), .core_irq(o[5]), .ext_irq(o[4]),
		.ext_supply_on(o[3]), .ext_cyclic_supply(o[2]), .stop_wake_req(o[1]),
		.ext_fault_wake(o[0]));
	// 200 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Settle: two sync stages, flag, irq, plus margin
	task settle(input int n);
		repeat (n) @(negedge clock);
	endtask
	// Word access at an offset; reads compare data
	task acc(input logic w, input logic [11:0] f, input logic [31:0] d, input logic [31:0] e);
		bm_u.xfer(w, 32'h5000_4000 + f, 2'b10, d, q, ans);
		chk({30'h0, ans}, 32'h0000_0001);
		if (!w)
			chk(q, e);
	endtask
	task t_bus;
		acc(0, 12'h008, 0, 32'h0000_0000);
		acc(0, 12'h00C, 0, 32'h0000_0000);
		acc(1, 12'h010, 32'hFFFF_FFFF, 0);
		acc(0, 12'h010, 0, 32'h0000_0000);
		bm_u.xfer(1, 32'h5000_4008, 2'b01, 32'h0000_0044, q, ans);
		chk({30'h0, ans}, 32'h0000_0002);
		bm_u.xfer(0, 32'h5000_4009, 2'b10, 0, q, ans);
		chk({30'h0, ans}, 32'h0000_0002);
		bm_u.xfer(0, 32'h5000_5008, 2'b10, 0, q, ans);
		chk({30'h0, ans}, 32'h0000_0000);
		acc(0, 12'h008, 0, 32'h0000_0000);
		$display("bus test done");
	endtask
	task t_status;
		cond[7:3] = 5'h1F;
		settle(5);
		cond[7:3] = 5'h00;
		settle(5);
		acc(0, 12'h008, 0, 32'h0000_003B);
		chk({30'h0, o[8:7]}, 32'h0000_0003);
		chk({30'h0, o[6:5]}, 32'h0000_0000);
		acc(1, 12'h008, 32'h0000_0044, 0);
		settle(2);
		chk({30'h0, o[6:5]}, 32'h0000_0003);
		acc(0, 12'h008, 0, 32'h0000_007F);
		acc(1, 12'h008, 32'h0000_2044, 0);
		acc(0, 12'h008, 0, 32'h0000_005F);
		acc(1, 12'h008, 32'h0000_1844, 0);
		acc(0, 12'h008, 0, 32'h0000_0047);
		acc(1, 12'h008, 32'h0000_0344, 0);
		acc(0, 12'h008, 0, 32'h0000_0044);
		settle(2);
		chk({30'h0, o[6:5]}, 32'h0000_0000);
		chk({30'h0, o[8:7]}, 32'h0000_0000);
		acc(1, 12'h008, 32'h0000_0000, 0);
		cond[4] = 1'b1;
		settle(5);
		chk({30'h0, o[6:5]}, 32'h0000_0000);
		acc(1, 12'h008, 32'h0000_0204, 0);
		settle(2);
		chk({30'h0, o[6:5]}, 32'h0000_0001);
		cond[4] = 1'b0;
		acc(0, 12'h008, 0, 32'h0000_0006);
		$display("status test done");
	endtask
	task t_ext;
		acc(1, 12'h00C, 32'h0000_3801, 0);
		acc(1, 12'h00C, 32'h0000_3803, 0);
		settle(2);
		chk({30'h0, o[3:2]}, 32'h0000_0003);
		cond[2:0] = 3'b111;
		settle(5);
		acc(0, 12'h00C, 0, 32'h0000_00FB);
		acc(1, 12'h00C, 32'h0000_3807, 0);
		settle(2);
		chk({31'h0, o[4]}, 32'h0000_0001);
		stop_mode = 1'b1;
		settle(3);
		chk({30'h0, o[1:0]}, 32'h0000_0003);
		stop_mode = 1'b0;
		cond[1:0] = 2'b00;
		settle(5);
		chk({30'h0, o[1:0]}, 32'h0000_0001);
		acc(1, 12'h00C, 32'h0000_3007, 0);
		acc(0, 12'h00C, 0, 32'h0000_00B7);
		acc(1, 12'h00C, 32'h0000_1807, 0);
		acc(0, 12'h00C, 0, 32'h0000_0097);
		acc(1, 12'h00C, 32'h0000_2807, 0);
		acc(0, 12'h00C, 0, 32'h0000_0087);
		settle(2);
		chk({31'h0, o[4]}, 32'h0000_0000);
		cond[0] = 1'b1;
		settle(5);
		chk({31'h0, o[4]}, 32'h0000_0001);
		rst_irq_b = 1'b0;
		settle(2);
		rst_irq_b = 1'b1;
		cond[0] = 1'b0;
		settle(5);
		acc(0, 12'h00C, 0, 32'h0000_0087);
		chk({31'h0, o[4]}, 32'h0000_0000);
		acc(1, 12'h00C, 32'h0000_3802, 0);
		settle(2);
		chk({30'h0, o[3:2]}, 32'h0000_0000);
		$display("external supply test done");
	endtask
	// Hang guard, well past the roughly 135 cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clock);
		fail_count++;
		finish_test;
	end
	// Reset for 12 cycles, then the tests in order
	initial
	begin
		rst_b = 1'b0;
		rst_irq_b = 1'b0;
		stop_mode = 1'b0;
		cond = 8'h00;
		repeat (12) @(negedge clock);
		rst_b = 1'b1;
		rst_irq_b = 1'b1;
		settle(3);
		t_bus;
		t_status;
		t_ext;
		finish_test;
	end
endmodule
`default_nettype wire
